// File: core/mise_pkg.sv
package mise_pkg;
    // operand and address widths
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned PC_W        = 13;

    // operation selector codes presented by the decode stage
    typedef enum logic [2:0] {
        MISE_OP_NONE         = 3'b000,
        MISE_OP_ADD_INTO_MEM = 3'b001,
        MISE_OP_AND_MEM      = 3'b010,
        MISE_OP_AND_IMM      = 3'b011,
        MISE_OP_AND_TO_MEM   = 3'b100,
        MISE_OP_CALL         = 3'b101,
        MISE_OP_CLEAR        = 3'b110
    } mise_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        MISE_ST_IDLE     = 2'b00,
        MISE_ST_CALL2    = 2'b01
    } mise_state_t;

    // reset values and constants
    localparam logic [DATA_W-1:0] WREG_RST   = 8'h00;
    localparam logic [DATA_W-1:0] CLEAR_VAL  = 8'h00;
    localparam logic [PC_W-1:0]   PC_RST     = 13'h0000;
    localparam logic [PC_W-1:0]   PC_STEP    = 13'h0001;
    localparam int unsigned       CALL_CYCLES = 2;
endpackage : mise_pkg

// File: core/mise_alu.sv
`timescale 1ns/10ps
// combinational 8-bit adder and and-unit with flag outputs
module mise_alu
    import mise_pkg::*;
(
    input  wire logic [DATA_W-1:0] a_i,
    input  wire logic [DATA_W-1:0] b_i,
    output logic      [DATA_W-1:0] sum_o,
    output logic      [DATA_W-1:0] and_o,
    output logic                   carry_o,
    output logic                   half_carry_o,
    output logic                   sign_wrap_o
);
    logic [DATA_W:0] wide_sum;
    logic [4:0]      low_sum;

    // sum with carry out of bit 7 and bit 3
    always_comb
    begin
        wide_sum     = {1'b0, a_i} + {1'b0, b_i};
        low_sum      = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
        sum_o        = wide_sum[DATA_W-1:0];
        carry_o      = wide_sum[DATA_W];
        half_carry_o = low_sum[4];
        // signed wrap: operands agree in sign, result does not
        sign_wrap_o  = (a_i[DATA_W-1] == b_i[DATA_W-1]) &&
                       (wide_sum[DATA_W-1] != a_i[DATA_W-1]);
        and_o        = a_i & b_i;
    end
endmodule // mise_alu

// File: core/mise_exec.sv
// Notes on behaviour
// - add-into-memory stores wreg plus memory byte back and updates all four flags.
// - and-with-memory puts wreg AND memory byte into wreg, only the zero flag changes.
// - and-with-immediate puts wreg AND immediate into wreg, only the zero flag changes.
// - and-into-memory writes memory byte AND wreg back to memory, not to wreg.
// - call pushes program counter plus one, loads the target address, leaves flags alone.
// - call takes two instruction cycles.
// - clear-location writes 00H to the memory byte and leaves flags alone.
`timescale 1ns/10ps
module mise_exec
    import mise_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_b_i,
    input  wire logic              issue_i,
    input  wire logic [2:0]        op_i,
    input  wire logic [ADDR_W-1:0] mem_addr_i,
    input  wire logic [DATA_W-1:0] imm_i,
    input  wire logic [PC_W-1:0]   call_target_i,
    input  wire logic [DATA_W-1:0] mem_rdata_i,
    output logic                   ready_o,
    output logic                   mem_we_o,
    output logic [ADDR_W-1:0]      mem_addr_o,
    output logic [DATA_W-1:0]      mem_wdata_o,
    output logic                   push_o,
    output logic [PC_W-1:0]        push_data_o,
    output logic [PC_W-1:0]        pc_o,
    output logic [DATA_W-1:0]      working_register_o,
    output logic                   zero_flag_o,
    output logic                   carry_flag_o,
    output logic                   half_carry_flag_o,
    output logic                   sign_wrap_flag_o
);
    // registered state and the values it takes at the next edge
    mise_state_t       state;
    mise_state_t       next_state;
    logic [DATA_W-1:0] working_register;
    logic [DATA_W-1:0] next_working_register;
    logic [PC_W-1:0]   pc;
    logic [PC_W-1:0]   next_pc;
    logic              zero_flag;
    logic              next_zero_flag;
    logic              carry_flag;
    logic              next_carry_flag;
    logic              half_carry_flag;
    logic              next_half_carry_flag;
    logic              sign_wrap_flag;
    logic              next_sign_wrap_flag;
    logic              mem_we;
    logic              next_mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [ADDR_W-1:0] next_mem_addr;
    logic [DATA_W-1:0] mem_wdata;
    logic [DATA_W-1:0] next_mem_wdata;
    logic              push;
    logic              next_push;
    logic [PC_W-1:0]   push_data;
    logic [PC_W-1:0]   next_push_data;
    // arithmetic unit hookup
    logic [DATA_W-1:0] alu_b;
    logic [DATA_W-1:0] alu_sum;
    logic [DATA_W-1:0] alu_and;
    logic              alu_carry;
    logic              alu_half;
    logic              alu_wrap;
    mise_op_t          op;

    // decode stage code seen through the package enum
    assign op    = mise_op_t'(op_i);
    // immediate operand replaces the memory byte only for and-with-immediate
    assign alu_b = (op == MISE_OP_AND_IMM) ? imm_i : mem_rdata_i;

    // shared arithmetic unit, operand a is always the working register
    mise_alu u_alu (
        .a_i          (working_register),
        .b_i          (alu_b),
        .sum_o        (alu_sum),
        .and_o        (alu_and),
        .carry_o      (alu_carry),
        .half_carry_o (alu_half),
        .sign_wrap_o  (alu_wrap)
    );

    // no new issue accepted during the second call cycle
    // a refused issue is dropped, so the decode stage must present it again
    assign ready_o = (state == MISE_ST_IDLE);

    // next-state and datapath decisions
    always_comb
    begin
        next_state           = state;
        next_working_register = working_register;
        next_pc              = pc;
        next_zero_flag       = zero_flag;
        next_carry_flag      = carry_flag;
        next_half_carry_flag = half_carry_flag;
        next_sign_wrap_flag  = sign_wrap_flag;
        next_mem_we          = 1'b0;
        next_mem_addr        = mem_addr;
        next_mem_wdata       = mem_wdata;
        next_push            = 1'b0;
        next_push_data       = push_data;
        unique case (state)
            MISE_ST_IDLE:
            begin
                if (issue_i)
                begin
                    // single-cycle ops step the counter once
                    next_pc = pc + PC_STEP;
                    case (op)
                        MISE_OP_ADD_INTO_MEM:
                        begin
                            // sum goes to memory only, the register keeps its value
                            next_mem_we          = 1'b1;
                            next_mem_addr        = mem_addr_i;
                            next_mem_wdata       = alu_sum;
                            next_zero_flag       = (alu_sum == CLEAR_VAL);
                            next_carry_flag      = alu_carry;
                            next_half_carry_flag = alu_half;
                            next_sign_wrap_flag  = alu_wrap;
                        end
                        MISE_OP_AND_MEM:
                        begin
                            next_working_register = alu_and;
                            next_zero_flag        = (alu_and == CLEAR_VAL);
                        end
                        MISE_OP_AND_IMM:
                        begin
                            next_working_register = alu_and;
                            next_zero_flag        = (alu_and == CLEAR_VAL);
                        end
                        MISE_OP_AND_TO_MEM:
                        begin
                            // flags held, unlike and-with-memory; result goes to memory instead of wreg
                            next_mem_we    = 1'b1;
                            next_mem_addr  = mem_addr_i;
                            next_mem_wdata = alu_and;
                        end
                        MISE_OP_CALL:
                        begin
                            next_push      = 1'b1;
                            next_push_data = pc + PC_STEP;
                            next_pc        = pc;
                            next_state     = MISE_ST_CALL2;
                        end
                        MISE_OP_CLEAR:
                        begin
                            // flags held, a cleared byte is no arithmetic result
                            next_mem_we    = 1'b1;
                            next_mem_addr  = mem_addr_i;
                            next_mem_wdata = CLEAR_VAL;
                        end
                        default:
                        begin
                            // unknown or idle code: just advance
                            next_pc = pc + PC_STEP;
                        end
                    endcase
                end
            end
            MISE_ST_CALL2:
            begin
                // extra cycle redirects flow; flags untouched
                next_pc    = call_target_i;
                next_state = MISE_ST_IDLE;
            end
            default:
            begin
                next_state = MISE_ST_IDLE;
            end
        endcase
    end

    // register all state
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state            <= MISE_ST_IDLE;
            working_register <= WREG_RST;
            pc               <= PC_RST;
            zero_flag        <= 1'b0;
            carry_flag       <= 1'b0;
            half_carry_flag  <= 1'b0;
            sign_wrap_flag   <= 1'b0;
            mem_we           <= 1'b0;
            mem_addr         <= '0;
            mem_wdata        <= '0;
            push             <= 1'b0;
            push_data        <= PC_RST;
        end
        else
        begin
            state            <= next_state;
            working_register <= next_working_register;
            pc               <= next_pc;
            zero_flag        <= next_zero_flag;
            carry_flag       <= next_carry_flag;
            half_carry_flag  <= next_half_carry_flag;
            sign_wrap_flag   <= next_sign_wrap_flag;
            mem_we           <= next_mem_we;
            mem_addr         <= next_mem_addr;
            mem_wdata        <= next_mem_wdata;
            push             <= next_push;
            push_data        <= next_push_data;
        end
    end

    // registered outputs
    assign mem_we_o           = mem_we;
    assign mem_addr_o         = mem_addr;
    assign mem_wdata_o        = mem_wdata;
    assign push_o             = push;
    assign push_data_o        = push_data;
    assign pc_o               = pc;
    assign working_register_o = working_register;
    assign zero_flag_o        = zero_flag;
    assign carry_flag_o       = carry_flag;
    assign half_carry_flag_o  = half_carry_flag;
    assign sign_wrap_flag_o   = sign_wrap_flag;
endmodule // mise_exec

// File: tb/mise_exec_sva.sv
`timescale 1ns/10ps
// port watcher for the executor; only call spans two steps
module mise_exec_sva
    import mise_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_b_i,
    input wire logic              issue_i,
    input wire logic [2:0]        op_i,
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic [DATA_W-1:0] imm_i,
    input wire logic [PC_W-1:0]   call_target_i,
    input wire logic [DATA_W-1:0] mem_rdata_i,
    input wire logic              ready_o,
    input wire logic              mem_we_o,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic [DATA_W-1:0] mem_wdata_o,
    input wire logic              push_o,
    input wire logic [PC_W-1:0]   push_data_o,
    input wire logic [PC_W-1:0]   pc_o,
    input wire logic [DATA_W-1:0] working_register_o,
    input wire logic              zero_flag_o,
    input wire logic              carry_flag_o
);
    // a request only counts when the sequencer is free
    wire logic       take = issue_i && ready_o;
    wire logic [1:0] flg  = {zero_flag_o, carry_flag_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // second call cycle blocks issue, then frees it
    sequence call_tail_s;
        !ready_o ##1 ready_o;
    endsequence
    call_push_a: assert property (take && op_i == MISE_OP_CALL
        |=> push_o && push_data_o == $past(pc_o) + PC_STEP) else $error("call push");
    call_cycles_a: assert property (take && op_i == MISE_OP_CALL
        |=> call_tail_s) else $error("call length");
    call_pc_a: assert property (take && op_i == MISE_OP_CALL
        |=> flg == $past(flg) ##1 pc_o == $past(call_target_i)) else $error("call target");
    add_mem_a: assert property (take && op_i == MISE_OP_ADD_INTO_MEM
        |=> mem_we_o && mem_wdata_o == $past(working_register_o + mem_rdata_i)
        && zero_flag_o == (mem_wdata_o == 8'h00)) else $error("add into memory");
    and_mem_a: assert property (take && op_i == MISE_OP_AND_MEM
        |=> working_register_o == $past(working_register_o & mem_rdata_i) && !mem_we_o
        && $stable(carry_flag_o)) else $error("and memory");
    and_imm_a: assert property (take && op_i == MISE_OP_AND_IMM
        |=> working_register_o == $past(working_register_o & imm_i)
        && zero_flag_o == (working_register_o == 8'h00)) else $error("and immediate");
    and_to_mem_a: assert property (take && op_i == MISE_OP_AND_TO_MEM
        |=> mem_we_o && mem_wdata_o == $past(mem_rdata_i & working_register_o)
        && $stable(working_register_o)) else $error("and into memory");
    clear_loc_a: assert property (take && op_i == MISE_OP_CLEAR
        |=> mem_we_o && mem_wdata_o == CLEAR_VAL && mem_addr_o == $past(mem_addr_i)
        && $stable(flg)) else $error("clear location");
endmodule // mise_exec_sva

bind mise_exec mise_exec_sva u_sva (.*);

// File: tb/mise_mem_model.sv
`timescale 1ns/10ps
// data memory: read follows the address in the same cycle
module mise_mem_model
    import mise_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [ADDR_W-1:0] raddr_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] waddr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic      [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [256];
    // byte i holds i, so the bench knows every operand
    initial
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i);
    assign rdata_o = mem[raddr_i];
    // write lands on the strobe edge only
    always @(posedge clk_i)
        if (we_i)
            mem[waddr_i] <= wdata_i;
endmodule // mise_mem_model

// File: tb/mise_exec_tb.sv
`timescale 1ns/10ps
module mise_exec_tb;
    import mise_pkg::*;
    logic clk_i = 1'b0, rst_b_i = 1'b0, issue_i = 1'b0;
    logic [2:0] op_i = 3'h0;
    logic [7:0] mem_addr_i = 8'h00, imm_i = 8'h00, mem_rdata_i, mem_addr_o, mem_wdata_o;
    logic [7:0] working_register_o;
    logic [12:0] call_target_i = 13'h0000, push_data_o, pc_o, exp_pc = PC_RST;
    logic ready_o, mem_we_o, push_o, zero_flag_o, carry_flag_o, half_carry_flag_o;
    logic sign_wrap_flag_o;
    int failures = 0, samples_checked = 0;
    always #4 clk_i = ~clk_i;
    mise_exec DUT (.*);
    mise_mem_model u_mem (.clk_i(clk_i), .raddr_i(mem_addr_i), .we_i(mem_we_o),
        .waddr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one non-call instruction, then look in the answer cycle
    task run(input logic [2:0] o, input logic [7:0] a, input logic [7:0] x);
        @(posedge clk_i);
        {issue_i, op_i, mem_addr_i, imm_i} <= {1'b1, o, a, x};
        @(posedge clk_i);
        issue_i <= 1'b0;
        @(negedge clk_i);
        exp_pc++;
    endtask
    // wreg never leaves zero here, so carries and wraps stay clear
    task look(input logic we, input logic [7:0] wd, input logic [7:0] ad, input logic z);
        chk("mem_we_o", mem_we_o, we);
        chk("mem_wdata_o", mem_wdata_o, wd);
        chk("mem_addr_o", mem_addr_o, ad);
        chk("zero_flag_o", zero_flag_o, z);
        chk("flags", {carry_flag_o, half_carry_flag_o, sign_wrap_flag_o}, 0);
        chk("working_register_o", working_register_o, 0);
        chk("pc_o", pc_o, exp_pc);
    endtask
    task t_add();
        run(MISE_OP_ADD_INTO_MEM, 8'h80, 0);
        look(1, 8'h80, 8'h80, 0);
        run(MISE_OP_ADD_INTO_MEM, 8'h00, 0);
        look(1, 8'h00, 8'h00, 1);
        $display("test add finished");
    endtask
    task t_and();
        run(MISE_OP_ADD_INTO_MEM, 8'h80, 0);
        run(MISE_OP_AND_MEM, 8'h80, 0);
        look(0, 8'h80, 8'h80, 1);
        run(MISE_OP_ADD_INTO_MEM, 8'h80, 0);
        run(MISE_OP_AND_IMM, 8'h00, 8'hFF);
        look(0, 8'h80, 8'h80, 1);
        run(MISE_OP_ADD_INTO_MEM, 8'h80, 0);
        run(MISE_OP_AND_TO_MEM, 8'h55, 0);
        look(1, 8'h00, 8'h55, 0);
        $display("test and finished");
    endtask
    // clear, then re-add to prove the zero byte really landed
    task t_clear();
        run(MISE_OP_CLEAR, 8'h80, 0);
        look(1, 8'h00, 8'h80, 0);
        run(MISE_OP_ADD_INTO_MEM, 8'h80, 0);
        look(1, 8'h00, 8'h80, 1);
        $display("test clear finished");
    endtask
    // a clear offered in the busy cycle must be ignored
    task t_call();
        @(posedge clk_i);
        {issue_i, op_i, call_target_i} <= {1'b1, MISE_OP_CALL, 13'h1ABC};
        @(posedge clk_i);
        {op_i, mem_addr_i} <= {MISE_OP_CLEAR, 8'h10};
        @(negedge clk_i);
        chk("push_o", push_o, 1);
        chk("push_data_o", push_data_o, exp_pc + 13'h0001);
        chk("ready_o", ready_o, 0);
        @(posedge clk_i);
        issue_i <= 1'b0;
        @(negedge clk_i);
        exp_pc = 13'h1ABC;
        chk("push_o", push_o, 0);
        chk("ready_o", ready_o, 1);
        look(0, 8'h00, 8'h80, 1);
        $display("test call finished");
    endtask
    task conclude();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_add();
        t_and();
        t_clear();
        t_call();
        conclude();
    end
    // under forty cycles of work, so this leaves wide margin
    initial
    begin
        repeat (1000) @(posedge clk_i);
        failures++;
        conclude();
    end
endmodule // mise_exec_tb
